/* sesw_master.sv */
// sesw_master: behavioural two-wire bus master, driven by task calls.
// assumes a pull-up outside; sda_low high pulls the data line down.
`timescale 1ns/1ps
module sesw_master (
   input wire logic clk_sys, // paces the bus at 80 ns a bit
   input wire logic sda_in, // resolved data level
   output logic scl, // bus clock, still and high outside frames
   output logic sda_low // high pulls data low
);
   initial begin
      scl = 1'b1;
      sda_low = 1'b0;
   end
   // a quarter bit time, 20 ns
   task automatic q;
      repeat (4) @(negedge clk_sys);
   endtask
   task automatic start;
      sda_low = 1'b0;
      q();
      scl = 1'b1;
      q();
      sda_low = 1'b1;
      q();
      scl = 1'b0;
      q();
   endtask
   task automatic stop;
      sda_low = 1'b1;
      q();
      scl = 1'b1;
      q();
      sda_low = 1'b0;
      q();
   endtask
   task automatic bit_io(input logic b, output logic r);
      sda_low = ~b;
      q();
      scl = 1'b1;
      q();
      r = sda_in;
      q();
      scl = 1'b0;
      q();
   endtask
   task automatic xbyte(input logic [7:0] d, input logic mack,
                        output logic [7:0] r, output logic nak);
      logic b;
      for (int i = 7; i >= 0; i--) begin
         bit_io(d[i], b);
         r[i] = b;
      end
      bit_io(~mack, nak);
   endtask
endmodule // sesw_master

/* sesw_pkg.sv */
// sesw_pkg: constants for the two-wire serial eeprom slave write and read paths.
// assumes a 200 MHz system clock that samples the bus pins.
package sesw_pkg;
   // array geometry
   localparam int ADDR_W = 11;               // 2048 bytes
   localparam int DATA_W = 8;                // byte wide
   localparam int PAGE_W = 7;                // 128 pages
   localparam int OFFS_W = 4;                // 16 bytes a page
   localparam int PAGE_BYTES = 16;           // page buffer depth
   localparam int MEM_BYTES = 2048;          // data array depth
   localparam int PAGES = 128;               // protection bits

   // command byte field positions
   localparam int CMD_FIXED_BIT = 7;         // must be one
   localparam int CMD_SEL2_BIT = 6;          // compared with pin 2
   localparam int CMD_SEL1_BIT = 5;          // inverted_select_bit_mid
   localparam int CMD_SEL0_BIT = 4;          // compared with pin 0
   localparam int CMD_ADDR_HI = 3;           // address_bit_top
   localparam int CMD_ADDR_LO = 1;           // address bit 8
   localparam int CMD_DIR_BIT = 0;           // 0 write, 1 read

   // byte framing
   localparam logic [3:0] BIT_LAST = 4'h8;   // rises before ack slot
   localparam logic [3:0] BIT_ACK = 4'h9;    // count after ack rise
   localparam logic [DATA_W-1:0] ERASED = 8'hFF; // erased byte
   localparam logic [PAGES-1:0] PROT_RESET = {PAGES{1'b1}}; // unprotected

   // pin synchroniser lane positions
   localparam int PIN_N = 6;                 // synchronised pins
   localparam int PIN_SDA = 0;
   localparam int PIN_SCL = 1;
   localparam int PIN_SEL0 = 2;
   localparam int PIN_SEL1 = 3;
   localparam int PIN_SEL2 = 4;
   localparam int PIN_WP = 5;

   // programming time
   localparam int CLK_MHZ = 200;             // system clock rate
   localparam int PROG_TIME_MS = 8;          // longest erase/write
   localparam int PROG_CYCLES_DEF = PROG_TIME_MS * 1000 * CLK_MHZ;
   localparam int PROG_CNT_W = 21;           // holds 1,600,000
   localparam int STEP_W = 6;                // erase + write sweep

   // bus-side states
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,                      // standby or deselected
      ST_CMD = 3'b001,                       // receiving command byte
      ST_ADDR = 3'b010,                      // receiving address byte
      ST_WDATA = 3'b011,                     // receiving write data
      ST_RDATA = 3'b100                      // sending read data
   } sesw_state_type;
endpackage

/* sesw_props.sv */
// sesw_props: bus and programming-timer checks for sesw_slave.
// assumes it sees only the slave's ports, bound in below.
`timescale 1ns/1ps
module sesw_props #(
   parameter int PROG_CYCLES = sesw_pkg::PROG_CYCLES_DEF // erase/write clocks
) (
   input wire logic clk_sys, // system clock
   input wire logic rst_n, // async reset, active low
   input wire logic scl_in, // bus clock level
   input wire logic sda_in, // resolved data level
   input wire logic sda_out, // open-drain drive value
   input wire logic sda_oe, // high while pulling data low
   input wire logic chip_sel_pin_0, // strap 0
   input wire logic chip_sel_pin_1, // strap 1
   input wire logic chip_sel_pin_2, // strap 2
   input wire logic write_protect, // blocks programming
   input wire logic prog_busy // erase/write running
);
   logic [31:0] busy_cnt_r; // cycles spent busy so far
   logic [3:0] stop_age_r; // cycles since last stop, saturating
   logic sda_d_r; // data level one clock back
   wire logic stop_w = scl_in && sda_in && !sda_d_r; // stop seen now
   // helper counters; busy count clears while idle
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         busy_cnt_r <= '0;
         stop_age_r <= 4'hF;
         sda_d_r <= 1'b1;
      end else begin
         busy_cnt_r <= prog_busy ? busy_cnt_r + 32'h1 : 32'h0;
         stop_age_r <= stop_w ? 4'h0 :
            (stop_age_r == 4'hF ? stop_age_r : stop_age_r + 4'h1);
         sda_d_r <= sda_in;
      end
   end
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   // bus conditions as seen at the pins
   sequence start_s; scl_in && $fell(sda_in); endsequence
   sequence stop_s; scl_in && $rose(sda_in); endsequence
   sda_low_only_a: assert property (sda_oe |-> sda_out == 1'b0)
      else $error("data drive value not low");
   oe_steady_a: assert property ($rose(scl_in) |=> $stable(sda_oe)[*8])
      else $error("data drive moved while clock high");
   oe_rise_low_a: assert property ($rose(sda_oe) |-> !scl_in)
      else $error("data pulled low while clock high");
   oe_fall_low_a: assert property ($fell(sda_oe) |-> !scl_in)
      else $error("data released while clock high");
   busy_quiet_a: assert property (prog_busy |-> !sda_oe)
      else $error("acknowledge given while programming");
   busy_len_a: assert property ($fell(prog_busy) |->
      busy_cnt_r inside {[PROG_CYCLES-1:PROG_CYCLES+1]})
      else $error("programming time wrong");
   busy_after_stop_a: assert property ($rose(prog_busy) |->
      stop_age_r < 4'h8)
      else $error("programming launched without a stop");
   busy_wp_a: assert property ($rose(prog_busy) |->
      !$past(write_protect, 4))
      else $error("programming while write protected");
   stop_release_a: assert property (stop_s |-> (!sda_oe)[*8])
      else $error("data driven after stop");
   start_release_a: assert property (start_s |-> (!sda_oe)[*8])
      else $error("data driven after start");
endmodule // sesw_props
bind sesw_slave sesw_props #(.PROG_CYCLES(PROG_CYCLES)) props_i (
   .clk_sys(clk_sys), .rst_n(rst_n), .scl_in(scl_in), .sda_in(sda_in),
   .sda_out(sda_out), .sda_oe(sda_oe), .chip_sel_pin_0(chip_sel_pin_0),
   .chip_sel_pin_1(chip_sel_pin_1), .chip_sel_pin_2(chip_sel_pin_2),
   .write_protect(write_protect), .prog_busy(prog_busy));

/* sesw_slave.sv */
// sesw_slave: serial eeprom slave with byte/page write, read and timed
// programming. assumes external pull-up on the data line and that the
// bus pins are asynchronous to clk_sys, each sampled through two flops.
//
// Functional notes
// - slave only; clock line never driven
// - data fall with clock high: start
// - stop ends transfer, launches programming
// - standby after stop or finished programming
// - acknowledge low in ninth clock
// - data stable while clock high, msb first
// - respond only on matching select bits
// - command bit zero selects direction
// - write command supplies address bits ten..eight
// - next byte loads low address
// - keep reading while master acknowledges
// - address counter advances per data byte
// - byte write acknowledges command, address, data
// - erase to ones, then write buffer
// - programming done within eight milliseconds
// - one to sixteen bytes per page
// - only low four address bits increment
// - unaddressed page bytes stay unchanged
// - no command acknowledge while programming
// - write protect pin blocks all programming
// - protected page suppresses programming
`timescale 1ns/1ps
module sesw_slave #(
   parameter int PROG_CYCLES = sesw_pkg::PROG_CYCLES_DEF // erase/write time
) (
   input wire logic clk_sys,           // system clock, 200 MHz
   input wire logic rst_n,             // asynchronous reset, active low
   input wire logic scl_in,            // bus clock pin level
   input wire logic sda_in,            // bus data pin level
   output logic sda_out,               // data pin drive value, always low
   output logic sda_oe,                // high while pulling data low
   input wire logic chip_sel_pin_0,    // select strap 0
   input wire logic chip_sel_pin_1,    // select strap 1
   input wire logic chip_sel_pin_2,    // select strap 2
   input wire logic write_protect,     // high blocks all programming
   output logic prog_busy              // erase/write cycle running
);
   import sesw_pkg::*;

   // select match: fixed bit one, middle strap compared inverted
   function automatic logic sel_match(input logic [DATA_W-1:0] cmd,
                                      input logic [2:0] straps);
      sel_match = cmd[CMD_FIXED_BIT] &&
                  (cmd[CMD_SEL2_BIT] == straps[2]) &&
                  (cmd[CMD_SEL1_BIT] == !straps[1]) &&
                  (cmd[CMD_SEL0_BIT] == straps[0]);
   endfunction

   // storage; the arrays carry no reset, as a real array would not
   // unwritten bytes therefore read back unknown in simulation
   logic [DATA_W-1:0] mem [MEM_BYTES];      // data array
   logic [DATA_W-1:0] page_buf [PAGE_BYTES]; // page buffer
   logic [PAGES-1:0] prot_r;                // page protection, 1 = open

   // pin synchroniser, two stages
   // straps and protect are static in use, but share the same flops
   // so that no raw pin level ever reaches the decoding logic
   logic [PIN_N-1:0] pin_meta_r;            // first stage, read by stage 2 only
   logic [PIN_N-1:0] pin_sync_r;            // second stage
   logic scl_d_r;                           // previous synced clock
   logic sda_d_r;                           // previous synced data

   // bus-side state
   sesw_state_type state_r;                 // byte engine state
   sesw_state_type next_r;                  // state after ack slot
   logic [3:0] bit_cnt_r;                   // clock rises in this byte
   logic [DATA_W-1:0] shift_r;              // received bits
   logic [DATA_W-1:0] tx_r;                 // bits being sent
   logic ack_r;                             // pulling ack low
   logic tx_drv_r;                          // sending read data
   logic [ADDR_W-1:0] addr_r;               // internal address counter
   logic [PAGE_BYTES-1:0] mask_r;           // buffer bytes entered

   // programming engine
   logic prog_busy_r;                       // cycle running
   logic [PROG_CNT_W-1:0] prog_cnt_r;       // cycle timer
   logic [STEP_W-1:0] step_r;               // erase/write sweep index
   logic [PAGE_W-1:0] prog_page_r;          // page being programmed
   logic [PAGE_BYTES-1:0] prog_mask_r;      // bytes to program

   // synchronised pins and their edges
   wire scl_s = pin_sync_r[PIN_SCL];
   wire sda_s = pin_sync_r[PIN_SDA];
   wire wp_s = pin_sync_r[PIN_WP];
   wire [2:0] straps_s = {pin_sync_r[PIN_SEL2], pin_sync_r[PIN_SEL1],
                          pin_sync_r[PIN_SEL0]};
   wire scl_rise = scl_s && !scl_d_r;
   wire scl_fall = !scl_s && scl_d_r;
   wire start_cond = scl_s && scl_d_r && sda_d_r && !sda_s;
   wire stop_cond = scl_s && scl_d_r && !sda_d_r && sda_s;

   // decoding of the finished byte
   wire [DATA_W-1:0] rx_byte = shift_r;
   wire cmd_hit = sel_match(rx_byte, straps_s);
   wire cmd_read = rx_byte[CMD_DIR_BIT];
   wire cmd_ack = cmd_hit && !prog_busy_r;
   // byte_end is the clock fall after bit eight, slot_end the fall after
   // the acknowledge clock; both act while the clock is low
   wire byte_end = scl_fall && (bit_cnt_r == BIT_LAST);
   wire slot_end = scl_fall && (bit_cnt_r == BIT_ACK);
   // read bits shift on clock falls, so the line moves only while low
   wire mid_fall = scl_fall && (bit_cnt_r != 4'h0) && (bit_cnt_r < BIT_LAST);
   wire [OFFS_W-1:0] offs = addr_r[OFFS_W-1:0];
   wire [OFFS_W-1:0] offs_inc = offs + 4'h1;
   wire [ADDR_W-1:0] addr_inc = addr_r + 11'h001;
   wire [PAGE_W-1:0] cur_page = addr_r[ADDR_W-1:OFFS_W];
   wire prog_ok = !wp_s && prot_r[cur_page];
   // only a stop launches; a refused or restarted frame never reaches
   // ST_WDATA with entered bytes, so it can never program the array
   wire launch = stop_cond && (state_r == ST_WDATA) && (mask_r != '0) &&
                 prog_ok && !prog_busy_r;
   wire sweep_on = prog_busy_r && !step_r[STEP_W-1];
   wire [OFFS_W-1:0] sweep_idx = step_r[OFFS_W-1:0];
   wire sweep_wr = step_r[OFFS_W];
   wire prog_done = prog_busy_r &&
                    (prog_cnt_r == PROG_CNT_W'(PROG_CYCLES - 1));

   // pin sampling; only the second stage is looked at by logic
   // reset to ones, the idle bus level, so no false edge follows reset
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         pin_meta_r <= '1;
         pin_sync_r <= '1;
         scl_d_r <= 1'b1;
         sda_d_r <= 1'b1;
      end else begin
         pin_meta_r <= {write_protect, chip_sel_pin_2, chip_sel_pin_1,
                        chip_sel_pin_0, scl_in, sda_in};
         pin_sync_r <= pin_meta_r;
         scl_d_r <= pin_sync_r[PIN_SCL];
         sda_d_r <= pin_sync_r[PIN_SDA];
      end
   end

   // byte engine: bit count, framing and state
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         state_r <= ST_IDLE;
         next_r <= ST_IDLE;
         bit_cnt_r <= 4'h0;
      end else if (start_cond) begin
         state_r <= ST_CMD;
         next_r <= ST_IDLE;
         bit_cnt_r <= 4'h0;
      end else if (stop_cond) begin
         state_r <= ST_IDLE;
         bit_cnt_r <= 4'h0;
      end else if (state_r != ST_IDLE) begin
         if (scl_rise && bit_cnt_r < BIT_ACK) begin
            bit_cnt_r <= bit_cnt_r + 4'h1;
         end
         if (scl_rise && bit_cnt_r == BIT_LAST && state_r == ST_RDATA) begin
            // no ack from master ends read
            if (sda_s) begin
               state_r <= ST_IDLE;
            end
         end
         if (byte_end) begin
            case (state_r)
               ST_CMD: begin
                  if (!cmd_ack) begin
                     state_r <= ST_IDLE;
                  end else if (cmd_read) begin
                     next_r <= ST_RDATA;
                  end else begin
                     next_r <= ST_ADDR;
                  end
               end
               ST_ADDR: next_r <= ST_WDATA;
               ST_WDATA: next_r <= ST_WDATA;
               ST_RDATA: next_r <= ST_RDATA;
               default: next_r <= ST_IDLE;
            endcase
         end
         if (slot_end) begin
            bit_cnt_r <= 4'h0;
            state_r <= next_r;
         end
      end
   end

   // receive shifter: sample on clock rise, msb first
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         shift_r <= '0;
      end else if (scl_rise && bit_cnt_r < BIT_LAST) begin
         shift_r <= {shift_r[DATA_W-2:0], sda_s};
      end
   end

   // data line drive: ack slot and read bits, released otherwise
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         ack_r <= 1'b0;
         tx_drv_r <= 1'b0;
         tx_r <= ERASED;
      end else if (start_cond || stop_cond) begin
         ack_r <= 1'b0;
         tx_drv_r <= 1'b0;
      end else if (byte_end) begin
         tx_drv_r <= 1'b0;
         case (state_r)
            ST_CMD: ack_r <= cmd_ack;
            ST_ADDR: ack_r <= 1'b1;
            ST_WDATA: ack_r <= 1'b1;
            default: ack_r <= 1'b0;
         endcase
      end else if (slot_end) begin
         ack_r <= 1'b0;
         if (next_r == ST_RDATA && state_r != ST_IDLE) begin
            // next read byte, changed while clock low
            tx_r <= mem[addr_r];
            tx_drv_r <= 1'b1;
         end else begin
            tx_drv_r <= 1'b0;
         end
      end else if (mid_fall && state_r == ST_RDATA) begin
         tx_r <= {tx_r[DATA_W-2:0], 1'b1};
      end else if (state_r == ST_IDLE) begin
         tx_drv_r <= 1'b0;
      end
   end

   // address counter and page mask
   // commands refused while busy leave the address untouched, though their start still clears the mask; after
   // a cycle the counter stays one past the last entered byte in the page
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         addr_r <= '0;
         mask_r <= '0;
      end else if (start_cond) begin
         mask_r <= '0;
      end else if (byte_end && !prog_busy_r) begin
         case (state_r)
            ST_CMD: begin
               // upper address only from a write command
               if (cmd_hit && !cmd_read) begin
                  addr_r[ADDR_W-1:DATA_W] <= rx_byte[CMD_ADDR_HI:CMD_ADDR_LO];
               end
            end
            ST_ADDR: addr_r[DATA_W-1:0] <= rx_byte;
            ST_WDATA: begin
               addr_r[OFFS_W-1:0] <= offs_inc;
               mask_r[offs] <= 1'b1;
            end
            default: mask_r <= mask_r;
         endcase
      end else if (slot_end && next_r == ST_RDATA && state_r != ST_IDLE) begin
         // read advances whole address, rolls over
         addr_r <= addr_inc;
      end
   end

   // page buffer fill on each acknowledged data byte
   always_ff @(posedge clk_sys) begin
      if (byte_end && state_r == ST_WDATA && !prog_busy_r) begin
         page_buf[offs] <= rx_byte;
      end
   end

   // programming engine: sweep then wait out the cycle time
   // limitation: PROG_CYCLES must cover the 32-step sweep, so it has
   // to be at least 32 clocks or the write pass is cut short
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         prog_busy_r <= 1'b0;
         prog_cnt_r <= '0;
         step_r <= '0;
         prog_page_r <= '0;
         prog_mask_r <= '0;
      end else if (launch) begin
         // stop after data starts the cycle
         prog_busy_r <= 1'b1;
         prog_cnt_r <= '0;
         step_r <= '0;
         prog_page_r <= cur_page;
         prog_mask_r <= mask_r;
      end else if (prog_done) begin
         prog_busy_r <= 1'b0;
      end else if (prog_busy_r) begin
         prog_cnt_r <= prog_cnt_r + 21'h000001;
         if (sweep_on) begin
            step_r <= step_r + 6'h01;
         end
      end
   end

   // array update: erase pass, then write pass, entered bytes only
   // the erase step mirrors the cell: each selected byte reads all ones
   // between the two passes, and bytes outside the mask are never touched
   always_ff @(posedge clk_sys) begin
      if (sweep_on && prog_mask_r[sweep_idx]) begin
         // erase to ones then write entered bytes
         mem[{prog_page_r, sweep_idx}] <= sweep_wr ? page_buf[sweep_idx]
                                                   : ERASED;
      end
   end

   // protection bits stay erased here; no command in this project clears them
   // kept as a register so a protection command path can later clear
   // bits without any change to the programming engine
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         prot_r <= PROT_RESET;
      end else begin
         prot_r <= prot_r;
      end
   end

   // only the data line is ever pulled; no clock output exists
   // open drain: pull low for ack or a zero data bit
   assign sda_out = 1'b0;
   assign sda_oe = ack_r || (tx_drv_r && !tx_r[DATA_W-1]);
   assign prog_busy = prog_busy_r;
endmodule // sesw_slave

/* testbench.sv */
// testbench: drives sesw_slave through the bus master model.
// assumes sesw_pkg, sesw_slave, sesw_props and sesw_master compiled.
`timescale 1ns/1ps
module testbench;
   import sesw_pkg::*;
   localparam int PROG = 300; // short, but outlasts one poll byte
   logic clk_sys, rst_n, sda_out, sda_oe, prog_busy, scl, m_low, wp;
   logic [2:0] cs; // select straps
   int bad_count, comparisons;
   // open-drain data line with pull-up
   wire logic sda = (sda_oe ? sda_out : 1'b1) & !m_low;
   sesw_slave #(.PROG_CYCLES(PROG)) dut (.clk_sys(clk_sys),
      .rst_n(rst_n), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
      .sda_oe(sda_oe), .chip_sel_pin_0(cs[0]), .chip_sel_pin_1(cs[1]),
      .chip_sel_pin_2(cs[2]), .write_protect(wp), .prog_busy(prog_busy));
   sesw_master m (.clk_sys(clk_sys), .sda_in(sda), .scl(scl),
      .sda_low(m_low));
   initial begin
      clk_sys = 1'b0;
      forever #2.5 clk_sys = ~clk_sys;
   end
   // command byte for this device's straps
   function automatic logic [7:0] cmd(input logic [2:0] hi,
                                      input logic rd);
      return {1'b1, cs[2], ~cs[1], cs[0], hi, rd};
   endfunction
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      comparisons++;
      if (seen !== exp) begin
         bad_count++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic close_out;
      $display("compared %0d, mismatched %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   // start, write command, low address
   task automatic setup(input logic [10:0] a);
      logic [7:0] r;
      logic n;
      m.start();
      m.xbyte(cmd(a[10:8], 1'b0), 1'b0, r, n);
      chk({7'h0, n}, 8'h00);
      m.xbyte(a[7:0], 1'b0, r, n);
      chk({7'h0, n}, 8'h00);
   endtask
   // write bytes, stop, poll once, then wait out the cycle
   task automatic wr(input logic [10:0] a, input logic [7:0] d [$],
                     input logic go);
      logic [7:0] r;
      logic n;
      int k;
      setup(a);
      foreach (d[i]) begin
         m.xbyte(d[i], 1'b0, r, n);
         chk({7'h0, n}, 8'h00);
      end
      m.stop();
      repeat (8) @(negedge clk_sys);
      chk({7'h0, prog_busy}, {7'h0, go});
      m.start();
      m.xbyte(cmd(3'h0, 1'b0), 1'b0, r, n);
      chk({7'h0, n}, {7'h0, go});
      m.stop();
      k = 0;
      while (prog_busy !== 1'b0 && k < 400) begin
         @(negedge clk_sys);
         k++;
      end
      chk({7'h0, prog_busy}, 8'h00);
   endtask
   // random read; read command's address bits are don't-care
   task automatic rd(input logic [10:0] a, input logic [7:0] e [$]);
      logic [7:0] r;
      logic n;
      setup(a);
      m.start();
      m.xbyte(cmd(3'h7, 1'b1), 1'b0, r, n);
      chk({7'h0, n}, 8'h00);
      foreach (e[i]) begin
         m.xbyte(8'hFF, i < e.size() - 1, r, n);
         chk(r, e[i]);
      end
      m.stop();
   endtask
   initial begin
      logic [7:0] r;
      logic n;
      rst_n = 1'b0;
      wp = 1'b0;
      cs = 3'b101;
      bad_count = 0;
      comparisons = 0;
      repeat (10) @(negedge clk_sys);
      rst_n = 1'b1;
      repeat (4) @(negedge clk_sys);
      wr(11'h5A3, '{8'h3C}, 1'b1);
      rd(11'h5A3, '{8'h3C});
      $display("byte write test done");
      wr(11'h112, '{8'h77}, 1'b1);
      wr(11'h11E, '{8'hA1, 8'hA2, 8'hA3, 8'hA4}, 1'b1);
      rd(11'h11E, '{8'hA1, 8'hA2});
      rd(11'h110, '{8'hA3, 8'hA4, 8'h77});
      $display("page write test done");
      // one wrong select or fixed bit at a time
      for (int b = 4; b < 8; b++) begin
         m.start();
         m.xbyte(cmd(3'h0, 1'b0) ^ (8'h01 << b), 1'b0, r, n);
         chk({7'h0, n}, 8'h01);
         m.stop();
      end
      $display("select test done");
      wp = 1'b1;
      wr(11'h5A3, '{8'h55}, 1'b0);
      wp = 1'b0;
      // data byte, then start in mid-byte aborts the write
      setup(11'h5A3);
      m.xbyte(8'h99, 1'b0, r, n);
      repeat (3) m.bit_io(1'b0, n);
      m.start();
      m.xbyte(cmd(3'h0, 1'b0), 1'b0, r, n);
      chk({7'h0, n}, 8'h00);
      m.stop();
      repeat (8) @(negedge clk_sys);
      chk({7'h0, prog_busy}, 8'h00);
      rd(11'h5A3, '{8'h3C});
      $display("protect and abort test done");
      // other strap setting: middle strap high, matched by a zero bit
      cs = 3'b010;
      rd(11'h5A3, '{8'h3C});
      $display("strap test done");
      close_out();
   end
   // watchdog, about two and a half times the expected run
   initial begin
      repeat (20000) @(posedge clk_sys);
      bad_count++;
      close_out();
   end
endmodule // testbench
